// File: shared/rir_pkg.sv
// Purpose: constants and carrier types of the restart interrupt unit
// Assumes: bus signals synchronous to sys_clk
// Notes: port numbers are the low address byte
package rir_pkg;
   localparam logic [7:0] CMD_PORT = 8'h02;
   localparam logic [7:0] VEC_PORT = 8'h03;
   localparam logic [15:0] VEC_RD_ADDR = 16'h0303;
   // command bit positions
   localparam int CMD_REINIT_BIT = 0;
   localparam int CMD_LOWSEL_BIT = 2;
   localparam int CMD_INTA_EN_BIT = 3;
   // request bit positions, highest priority at bit 0
   localparam int REQ_TMR1 = 0;
   localparam int REQ_TMR2 = 1;
   localparam int REQ_EXT = 2;
   localparam int REQ_TMR3 = 3;
   localparam int REQ_RX = 4;
   localparam int REQ_TX = 5;
   localparam int REQ_TMR4 = 6;
   localparam int REQ_LOW = 7;
   localparam int NUM_SRC = 8;
   // reset values, reinit pattern and opcode fill bits
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] REQ_RST = 8'h00;
   localparam logic [7:0] REINIT_REQ = 8'h20;
   localparam logic [7:0] VEC_IDLE = 8'hff;
   localparam logic [1:0] VEC_HI_ONES = 2'h3;
   localparam logic [2:0] VEC_LO_ONES = 3'h7;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] dout;
      logic s_inp;
      logic s_out;
      logic s_inta;
      logic p_dbin;
      logic p_wr_n;
   } rir_bus_t;

   typedef struct packed {
      logic [4:0] timer_evt;
      logic ext_evt;
      logic rx_full_evt;
      logic tx_empty_evt;
      logic parallel_in_bit_seven;
   } rir_src_t;
endpackage

// File: src/rir_irq_unit.sv
// Purpose: prioritised restart-opcode interrupt unit
// Assumes: bus strobes and sources are synchronous to sys_clk
// Notes: bus answers appear one clock after the strobes
//
// How it works
// - inta_response_enable set: acknowledge cycles get the vector on data-in
// - with it clear, acknowledge cycles cause no drive and no state change
// - lowest source is parallel bit seven when select is 0, else timer 5
// - soft_reinit pulses receiver search, marking line and timer clear
// - soft_reinit sets tx_empty_request and clears all other requests
// - soft_reinit written 0 does nothing; the bit self-clears after acting
// - vector always holds one of eight fixed restart opcodes
// - fixed priority from timer1 down; vector picks top unmasked request
// - vector read or acknowledge clears the encoded request, vector advances
// - vector reads all ones when nothing unmasked is pending
// - vector readable at port 03 regardless of inta_response_enable
// - mask bit 0 disables a source, 1 enables it
// - mask bits D0..D7 map to sources in priority order
// - requests latch while masked and wait for unmask or soft_reinit
// - pending sets pending_flag and drives interrupt pin low
// - boards chain grant out to next lower board's grant in
// - no acknowledge response while a higher board holds grant low
// - opcode is level_code in bits 5:3 with all other bits one
// - port read decodes address 0303, sINP and pDBIN all high
// - pending_flag is the or of enabled requests, falls when all serviced
`timescale 1ns/1ps
module rir_irq_unit #(
   parameter int NUM_TIMERS = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   input rir_pkg::rir_bus_t bus_i,
   input rir_pkg::rir_src_t src_i,
   input wire logic chain_grant_in,
   output logic [7:0] di_o,
   output logic di_oe_n,
   output logic int_n,
   output logic pending_flag,
   output logic chain_grant_out,
   output logic [7:0] req_latch_o,
   output logic rx_search_o,
   output logic serial_out_mark_o,
   output logic timer_clear_o,
   output logic soft_reinit_o
);
   import rir_pkg::*;

   if (NUM_TIMERS != 5) begin : g_chk
      $error("rir_irq_unit serves exactly five timers");
   end

   typedef struct packed {
      logic any;
      logic [2:0] lvl;
   } rir_enc_t;

   function automatic rir_enc_t rir_encode(input logic [7:0] act);
      rir_enc_t r;
      r.any = 1'b0;
      r.lvl = 3'h7;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (act[i]) begin
            r.any = 1'b1;
            r.lvl = 3'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] rir_opcode(input logic [2:0] lvl);
      return {VEC_HI_ONES, lvl, VEC_LO_ONES};
   endfunction

   logic [7:0] req_q;
   logic [7:0] mask_q;
   logic inta_en_q;
   logic low_sel_q;
   logic reinit_q;
   logic wr_prev_q;
   logic rd_prev_q;
   logic [2:0] cap_lvl_q;
   logic cap_any_q;
   logic [7:0] di_q;
   logic oe_n_q;
   logic int_n_q;
   logic pend_q;
   logic grant_q;
   logic rx_search_q;
   logic mark_q;
   logic tclr_q;

   logic [7:0] set_ev;
   logic [7:0] enabled;
   rir_enc_t enc;
   logic port_rd;
   logic inta_rd;
   logic rd_act;
   logic rd_start;
   logic rd_end;
   logic wr_act;
   logic wr_take;
   logic cmd_wr;
   logic mask_wr;
   logic [7:0] svc_clr;

   // source vector in priority order
   always_comb begin
      set_ev = 8'h00;
      set_ev[REQ_TMR1] = src_i.timer_evt[0];
      set_ev[REQ_TMR2] = src_i.timer_evt[1];
      set_ev[REQ_EXT] = src_i.ext_evt;
      set_ev[REQ_TMR3] = src_i.timer_evt[2];
      set_ev[REQ_RX] = src_i.rx_full_evt;
      set_ev[REQ_TX] = src_i.tx_empty_evt;
      set_ev[REQ_TMR4] = src_i.timer_evt[3];
      set_ev[REQ_LOW] = low_sel_q ? src_i.timer_evt[4] :
         src_i.parallel_in_bit_seven;
   end

   assign enabled = req_q & mask_q;
   assign enc = rir_encode(enabled);

   // bus decode
   assign port_rd = (bus_i.addr == VEC_RD_ADDR) && bus_i.s_inp &&
      bus_i.p_dbin;
   assign inta_rd = bus_i.s_inta && bus_i.p_dbin && inta_en_q &&
      chain_grant_in;
   assign rd_act = port_rd || inta_rd;
   assign rd_start = rd_act && !rd_prev_q;
   assign rd_end = rd_prev_q && !rd_act;
   assign wr_act = bus_i.s_out && !bus_i.p_wr_n;
   assign wr_take = wr_act && !wr_prev_q;
   assign cmd_wr = wr_take && (bus_i.addr[7:0] == CMD_PORT);
   assign mask_wr = wr_take && (bus_i.addr[7:0] == VEC_PORT);

   // request cleared at end of a read that carried a real request
   always_comb begin
      svc_clr = 8'h00;
      if (rd_end && cap_any_q) begin
         svc_clr[cap_lvl_q] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_act;
         rd_prev_q <= rd_act;
      end
   end

   // command register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         inta_en_q <= 1'b0;
         low_sel_q <= 1'b0;
         reinit_q <= 1'b0;
      end else begin
         reinit_q <= 1'b0;
         if (cmd_wr) begin
            inta_en_q <= bus_i.dout[CMD_INTA_EN_BIT];
            low_sel_q <= bus_i.dout[CMD_LOWSEL_BIT];
            reinit_q <= bus_i.dout[CMD_REINIT_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_q <= MASK_RST;
      end else if (mask_wr) begin
         mask_q <= bus_i.dout;
      end
   end

   // request latch; new events win over any clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_q <= REQ_RST;
      end else if (reinit_q) begin
         req_q <= REINIT_REQ | set_ev;
      end else begin
         req_q <= (req_q & ~svc_clr) | set_ev;
      end
   end

   // serial and timer side effects of soft_reinit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_search_q <= 1'b0;
         mark_q <= 1'b0;
         tclr_q <= 1'b0;
      end else begin
         rx_search_q <= reinit_q;
         mark_q <= reinit_q;
         tclr_q <= reinit_q;
      end
   end

   // vector capture and bus drive
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cap_lvl_q <= 3'h7;
         cap_any_q <= 1'b0;
         di_q <= VEC_IDLE;
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= !rd_act;
         if (rd_start) begin
            cap_lvl_q <= enc.lvl;
            cap_any_q <= enc.any;
            di_q <= enc.any ? rir_opcode(enc.lvl) : VEC_IDLE;
         end
      end
   end

   // pending, pin and chain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pend_q <= 1'b0;
         int_n_q <= 1'b1;
         grant_q <= 1'b1;
      end else begin
         pend_q <= |enabled;
         int_n_q <= ~(|enabled);
         grant_q <= chain_grant_in && !(|enabled);
      end
   end

   assign di_o = di_q;
   assign di_oe_n = oe_n_q;
   assign int_n = int_n_q;
   assign pending_flag = pend_q;
   assign chain_grant_out = grant_q;
   assign req_latch_o = req_q;
   assign rx_search_o = rx_search_q;
   assign serial_out_mark_o = mark_q;
   assign timer_clear_o = tclr_q;
   assign soft_reinit_o = reinit_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   ack_drive_a: assert property (
      (bus_i.s_inta && bus_i.p_dbin && inta_en_q && chain_grant_in)
      |=> !di_oe_n) else $error("acknowledge not answered");
   ack_quiet_a: assert property (
      (bus_i.s_inta && !inta_en_q && !port_rd) |=> di_oe_n &&
      ($stable(req_q) || $past(set_ev) != 8'h00 || $past(reinit_q) ||
      $past(rd_end)))
      else $error("acknowledge answered while disabled");
   low_select_a: assert property (
      (!low_sel_q && src_i.parallel_in_bit_seven) |=> req_q[REQ_LOW])
      else $error("low source not latched");
   reinit_side_a: assert property (
      reinit_q |=> rx_search_o && serial_out_mark_o && timer_clear_o)
      else $error("reinit side effects missing");
   reinit_req_a: assert property (
      (reinit_q && set_ev == 8'h00) |=> req_q == REINIT_REQ)
      else $error("reinit request pattern wrong");
   reinit_self_a: assert property (
      reinit_q && !cmd_wr |=> !reinit_q)
      else $error("reinit bit stuck");
   vec_form_a: assert property (
      !di_oe_n |-> di_o[7:6] == VEC_HI_ONES && di_o[2:0] == VEC_LO_ONES)
      else $error("vector not a restart opcode");
   vec_idle_a: assert property (
      (rd_start && enabled == 8'h00) |=> di_o == VEC_IDLE)
      else $error("idle vector not all ones");
   svc_clear_a: assert property (
      (rd_end && cap_any_q && !set_ev[cap_lvl_q] && !reinit_q)
      |=> !req_q[$past(cap_lvl_q)]) else $error("request not cleared");
   pend_pin_a: assert property (
      (|enabled) |=> !int_n ##0 pending_flag)
      else $error("pending not shown");
   pend_fall_a: assert property (
      (enabled == 8'h00) [*2] |-> !pending_flag ##0 int_n)
      else $error("pending flag stuck");
   chain_block_a: assert property (
      !chain_grant_in && !port_rd |=> di_oe_n)
      else $error("answered without grant");
   chain_out_a: assert property (
      (|enabled) |=> !chain_grant_out) else $error("grant passed on");
   poll_drive_a: assert property (
      port_rd |=> !di_oe_n)
      else $error("port read not answered");
   addr_miss_a: assert property (
      (bus_i.addr != VEC_RD_ADDR) && !bus_i.s_inta |=> di_oe_n)
      else $error("vector driven for a foreign port");
   inta_off_a: assert property (
      !inta_en_q && !port_rd |=> di_oe_n)
      else $error("drive while acknowledge disabled");
   top_prio_a: assert property (
      rd_start && enabled[REQ_TMR1] |=> di_o == rir_opcode(3'(REQ_TMR1)))
      else $error("top source not chosen");
   rx_level_a: assert property (
      rd_start && enabled == 8'(1 << REQ_RX)
      |=> di_o == rir_opcode(3'(REQ_RX)))
      else $error("receiver request at wrong level");
   vec_hold_a: assert property (
      rd_act && !rd_start |=> $stable(di_o))
      else $error("vector moved during a read");
   oe_release_a: assert property (
      rd_end |=> di_oe_n)
      else $error("driver left on after read");

   // request, command, mask, pin and chain checks
   low_timer_a: assert property (
      (low_sel_q && src_i.timer_evt[4]) |=> req_q[REQ_LOW])
      else $error("timer 5 not latched");
   low_ignore_a: assert property (
      (low_sel_q && !src_i.timer_evt[4] && !req_q[REQ_LOW]) |=> !req_q[REQ_LOW])
      else $error("deselected low source latched");
   req_keep_a: assert property (
      !reinit_q |=> ($past(req_q) & ~req_q & ~$past(svc_clr)) == 8'h00)
      else $error("request lost without service");
   reinit_tx_a: assert property (
      reinit_q |=> req_q[REQ_TX])
      else $error("reinit did not raise tx request");
   reinit_zero_a: assert property (
      cmd_wr && !bus_i.dout[CMD_REINIT_BIT] |=> !soft_reinit_o)
      else $error("reinit written 0 acted");
   mask_open_a: assert property (
      mask_wr |=> mask_q == $past(bus_i.dout))
      else $error("mask write lost");
   pend_int_a: assert property (
      pending_flag != int_n)
      else $error("pin and flag disagree");
   chain_pass_a: assert property (
      !chain_grant_in |=> !chain_grant_out)
      else $error("grant passed while upstream busy");
   grant_free_a: assert property (
      chain_grant_in && enabled == 8'h00 |=> chain_grant_out)
      else $error("grant held while idle");

   ack_seen_c: cover property (inta_rd ##1 rd_end);
   poll_seen_c: cover property (port_rd && enc.any);
   reinit_seen_c: cover property (reinit_q);
   masked_wait_c: cover property ((req_q != 8'h00) && enabled == 8'h00);
   chain_pass_c: cover property (!chain_grant_in && enabled == 8'h00);
endmodule

// File: dv/rir_hi_board.sv
// Purpose: higher-priority board ahead of the unit in the chain
// Assumes: request level from the bench, synchronous to sys_clk
// Notes: grant idles high, as an open chain input would
`timescale 1ns/1ps
module rir_hi_board (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hi_req,
   output logic grant_out
);
   // grant drops while this board wants service
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         grant_out <= 1'b1;
      end else begin
         grant_out <= !hi_req;
      end
   end
endmodule

// File: dv/tb_top.sv
// Purpose: self-checking bench of the restart interrupt unit
// Assumes: inputs move 2 ns after the rising edge
// Notes: vectors are worked out from level codes
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   import rir_pkg::*;
   logic sys_clk = 0, rst = 1, hi_req = 0, chain_grant_in, drv;
   rir_bus_t bus_i;
   rir_src_t src_i;
   logic [7:0] di_o, req_latch_o, v;
   logic di_oe_n, int_n, pending_flag, chain_grant_out;
   logic rx_search_o, serial_out_mark_o, timer_clear_o, soft_reinit_o;
   int errors = 0, num_checks = 0, cyc = 0, side = 0;
   rir_irq_unit i_rir_irq_unit (.sys_clk, .rst, .bus_i, .src_i,
      .chain_grant_in, .di_o, .di_oe_n, .int_n, .pending_flag,
      .chain_grant_out, .req_latch_o, .rx_search_o, .serial_out_mark_o,
      .timer_clear_o, .soft_reinit_o);
   rir_hi_board i_rir_hi_board (.sys_clk, .rst, .hi_req,
      .grant_out(chain_grant_in));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      cyc++;
      if (rx_search_o && serial_out_mark_o && timer_clear_o) side++;
      if (cyc == 3000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic step(int n = 1);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic wr(logic [7:0] p, logic [7:0] d);
      bus_i.addr = {p, p};
      bus_i.dout = d;
      bus_i.s_out = 1'b1;
      bus_i.p_wr_n = 1'b0;
      step();
      bus_i.s_out = 1'b0;
      bus_i.p_wr_n = 1'b1;
      step(2);
   endtask
   // port read (ack=0) or acknowledge cycle (ack=1)
   task automatic rd(logic ack, output logic [7:0] d);
      int i;
      bus_i.addr = ack ? 16'h0000 : VEC_RD_ADDR;
      bus_i.s_inta = ack;
      bus_i.s_inp = !ack;
      bus_i.p_dbin = 1'b1;
      step();
      for (i = 0; i < 3 && di_oe_n !== 1'b0; i++) step();
      // hold the strobes through the edge that samples the answer
      step();
      drv = (di_oe_n === 1'b0);
      d = di_o;
      bus_i.s_inta = 1'b0;
      bus_i.s_inp = 1'b0;
      bus_i.p_dbin = 1'b0;
      step(3);
   endtask
   task automatic ev(logic [8:0] x);
      src_i = rir_src_t'(x);
      step();
      src_i = '0;
      step(2);
   endtask
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      bus_i = '0;
      bus_i.p_wr_n = 1'b1;
      src_i = '0;
      repeat (6) @(posedge sys_clk);
      #2 rst = 0;
      step();
      rd(0, v);
      `CHK(v, VEC_IDLE)
      wr(CMD_PORT, 8'h01);
      `CHK(req_latch_o, REINIT_REQ)
      `CHK(soft_reinit_o, 1'b0)
      `CHK(side, 1)
      wr(CMD_PORT, 8'h00);
      `CHK(req_latch_o, REINIT_REQ)
      ev(9'h1fe);
      `CHK(req_latch_o, 8'h7f)
      `CHK(pending_flag, 1'b0)
      ev(9'h001);
      `CHK(req_latch_o, 8'hff)
      wr(VEC_PORT, 8'hff);
      `CHK(pending_flag, 1'b1)
      `CHK(int_n, 1'b0)
      `CHK(chain_grant_out, 1'b0)
      for (int i = 0; i < NUM_SRC; i++) begin
         rd(0, v);
         `CHK(v, 8'(8'hc7 | (i << 3)))
      end
      `CHK(pending_flag, 1'b0)
      `CHK(int_n, 1'b1)
      wr(CMD_PORT, 8'h04);
      ev(9'h100);
      `CHK(req_latch_o, 8'h80)
      wr(VEC_PORT, 8'h10);
      `CHK(pending_flag, 1'b0)
      ev(9'h004);
      rd(0, v);
      `CHK(v, 8'he7)
      `CHK(req_latch_o, 8'h80)
      wr(VEC_PORT, 8'hff);
      rd(1, v);
      `CHK(drv, 1'b0)
      `CHK(req_latch_o, 8'h80)
      bus_i.addr = 16'h0003;
      bus_i.s_inp = 1'b1;
      bus_i.p_dbin = 1'b1;
      step(3);
      `CHK(di_oe_n, 1'b1)
      bus_i.s_inp = 1'b0;
      bus_i.p_dbin = 1'b0;
      step(3);
      `CHK(req_latch_o, 8'h80)
      wr(CMD_PORT, 8'h0c);
      ev(9'h010);
      hi_req = 1'b1;
      step(2);
      rd(1, v);
      `CHK(drv, 1'b0)
      hi_req = 1'b0;
      step(2);
      rd(1, v);
      `CHK(drv, 1'b1)
      `CHK(v, 8'hc7)
      rd(0, v);
      `CHK(v, 8'hff)
      `CHK(req_latch_o, 8'h00)
      `CHK(chain_grant_out, 1'b1)
      hi_req = 1'b1;
      step(2);
      `CHK(chain_grant_out, 1'b0)
      hi_req = 1'b0;
      wrap_up();
   end
endmodule
